// file: dexp_defines.vh
// Constants for the double exposure gate sequencer
`ifndef DEXP_DEFINES_VH
`define DEXP_DEFINES_VH
`define ADR_CTRL 4'h0
`define ADR_STATUS 4'h1
`define ADR_DLY_START 4'h2
`define ADR_WID_START 4'h3
`define ADR_DLY_END 4'h4
`define ADR_WID_END 4'h5
`define ADR_BURST_PER 4'h6
`define ADR_SETTLE 4'h7
`define ADR_INT_PER 4'h8
`define ADR_BURST_CNT 4'h9
`define ADR_IMG_CNT 4'ha
`define CTRL_ENABLE 0
`define CTRL_TWO_TRIG 1
`define CTRL_STEPPED 2
`define CTRL_INT_TRIG 3
`define CTRL_GATED 4
`define PAIR_COUNT 2'h2
`define MARKER_CYCLES 16'h0004
`endif

// file: gate_pulse_timer.v
// One gated exposure: delay, gate width, then settle time
`timescale 1ns/100ps
`include "dexp_defines.vh"
module gate_pulse_timer #(
  parameter W = 32
) (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire start_i,
  input wire [W-1:0] delay_i,
  input wire [W-1:0] width_i,
  input wire [W-1:0] settle_i,
  output reg gate_o,
  output reg done_o,
  output reg busy_o
);
  localparam S_IDLE = 2'h0;
  localparam S_DLY = 2'h1;
  localparam S_GATE = 2'h2;
  localparam S_SET = 2'h3;
  reg [1:0] st_ff;
  reg [W-1:0] cnt_ff;
  reg [W-1:0] wid_ff;
  reg [W-1:0] set_ff;

  // Phases count down; a zero length phase still takes one cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= S_IDLE;
      cnt_ff <= {W{1'b0}};
      wid_ff <= {W{1'b0}};
      set_ff <= {W{1'b0}};
      gate_o <= 1'b0;
      done_o <= 1'b0;
      busy_o <= 1'b0;
    end else if (ce_i) begin
      done_o <= 1'b0;
      case (st_ff)
        S_IDLE: begin
          if (start_i) begin
            // Settings latched so mid-pulse writes cannot tear it
            cnt_ff <= delay_i;
            wid_ff <= width_i;
            set_ff <= settle_i;
            busy_o <= 1'b1;
            st_ff <= S_DLY;
          end
        end
        S_DLY: begin
          if (cnt_ff <= {{(W-1){1'b0}}, 1'b1}) begin
            cnt_ff <= wid_ff;
            gate_o <= 1'b1;
            st_ff <= S_GATE;
          end else begin
            cnt_ff <= cnt_ff - {{(W-1){1'b0}}, 1'b1};
          end
        end
        S_GATE: begin
          if (cnt_ff <= {{(W-1){1'b0}}, 1'b1}) begin
            cnt_ff <= set_ff;
            gate_o <= 1'b0;
            st_ff <= S_SET;
          end else begin
            cnt_ff <= cnt_ff - {{(W-1){1'b0}}, 1'b1};
          end
        end
        S_SET: begin
          // Settle lets phosphor decay before the image shift
          if (cnt_ff <= {{(W-1){1'b0}}, 1'b1}) begin // RL17
            done_o <= 1'b1;
            busy_o <= 1'b0;
            st_ff <= S_IDLE;
          end else begin
            cnt_ff <= cnt_ff - {{(W-1){1'b0}}, 1'b1};
          end
        end
        default: st_ff <= S_IDLE;
      endcase
    end
  end
endmodule

// file: double_exposure_gate_sequencer.v
// Double exposure sequencer with Wishbone registers
// Operation
// RL1 - One trigger launches both pair exposures
// RL2 - Burst mode gives exactly two pulses
// RL3 - Second start follows first by burst period
// RL4 - Host sets burst period covering pulse
// RL5 - Burst pulses share one width, delay
// RL6 - Two trigger mode: trigger per exposure
// RL7 - Repetitive gating reuses same width, delay
// RL8 - Stepped: start values first, end second
// RL9 - First image moved to storage, held
// RL10 - Second charge held until readout done
// RL11 - Trigger source external or internal
// RL12 - Internal start on marker rising edge
// RL13 - Source spaces triggers beyond pair sequence
// RL14 - Two trigger spacing beyond pulse time
// RL15 - Gated mode and image count two
// RL16 - Host downloads settings before acquisition
// RL17 - Wait settle time before image shift
// RL18 - Triggers during a pair are ignored
// RL19 - Two trigger mode rearms after pair
//
// The placing of the registers and the Wishbone slave port are this design's own decisions.
`timescale 1ns/100ps
`include "dexp_defines.vh"
module double_exposure_gate_sequencer #(
  parameter W = 32
) (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [5:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  input wire ext_trig_i,
  input wire readout_done_i,
  output reg gate_o,
  output reg transfer_o,
  output reg cycle_start_marker_o,
  output reg pair_busy_o
);
  localparam S_IDLE = 3'h0;
  localparam S_FIRST = 3'h1;
  localparam S_WAIT2 = 3'h2;
  localparam S_SECOND = 3'h3;
  localparam S_HOLD = 3'h4;

  // Host loaded settings
  reg [4:0] ctrl_ff;
  reg [W-1:0] dly_s_ff;
  reg [W-1:0] wid_s_ff;
  reg [W-1:0] dly_e_ff;
  reg [W-1:0] wid_e_ff;
  reg [W-1:0] bper_ff;
  reg [W-1:0] settle_ff;
  reg [W-1:0] iper_ff;
  reg [1:0] bcnt_ff;
  reg [1:0] icnt_ff;

  // Sequencer and marker state
  reg [2:0] st_ff;
  reg [W-1:0] bcount_ff;
  reg [W-1:0] icount_ff;
  reg [15:0] mk_ff;

  // Pin synchroniser stages; the third stage only feeds edge detection
  reg ext_s1_ff;
  reg ext_s2_ff;
  reg ext_s3_ff;
  reg rd_s1_ff;
  reg rd_s2_ff;
  reg rd_s3_ff;
  reg marker_q_ff;
  reg stored_ff;
  reg [7:0] pairs_ff;
  reg start_ff;
  reg sel_end_ff;
  wire p_gate, p_done, p_busy;
  wire two_trig = ctrl_ff[`CTRL_TWO_TRIG];
  wire stepped = ctrl_ff[`CTRL_STEPPED];
  // Triggers are only taken with a complete, legal setup
  wire cfg_ok = ctrl_ff[`CTRL_ENABLE] & ctrl_ff[`CTRL_GATED] & // RL15
                (icnt_ff == `PAIR_COUNT) & (two_trig | (bcnt_ff == `PAIR_COUNT)); // RL2
  wire ext_edge = ext_s2_ff & ~ext_s3_ff;
  // Readout done is a level that may still stand from the last pair,
  // so only its rising edge marks the end of a readout
  wire rd_rise = rd_s2_ff & ~rd_s3_ff;
  wire int_edge = cycle_start_marker_o & ~marker_q_ff; // RL12
  wire trig = ctrl_ff[`CTRL_INT_TRIG] ? int_edge : ext_edge; // RL11
  wire bus_req = cyc_i & stb_i & ~ack_o;
  wire [3:0] widx = adr_i[5:2];

  // Byte lane merge for a 32-bit register
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] sel;
    begin
      merge = {sel[3] ? nw[31:24] : old[31:24], sel[2] ? nw[23:16] : old[23:16],
               sel[1] ? nw[15:8] : old[15:8], sel[0] ? nw[7:0] : old[7:0]};
    end
  endfunction

  // Counter step shared by the burst spacing and marker period counters
  function [W-1:0] inc;
    input [W-1:0] v;
    begin
      inc = v + {{(W-1){1'b0}}, 1'b1};
    end
  endfunction

  // Control write image; only the low five bits are kept
  wire [31:0] ctrl_wr = merge({27'h0, ctrl_ff}, dat_i, sel_i);

  // Only the second exposure of a stepped two trigger pair uses end values
  gate_pulse_timer #(.W(W)) u_pulse (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .start_i(start_ff),
    .delay_i(sel_end_ff ? dly_e_ff : dly_s_ff), // RL8
    .width_i(sel_end_ff ? wid_e_ff : wid_s_ff), // RL8
    .settle_i(settle_ff),
    .gate_o(p_gate),
    .done_o(p_done),
    .busy_o(p_busy)
  );

  // Pin synchronisers
  always @(posedge clk_i) begin
    if (rst_i) begin
      ext_s1_ff <= 1'b0;
      ext_s2_ff <= 1'b0;
      ext_s3_ff <= 1'b0;
      rd_s1_ff <= 1'b0;
      rd_s2_ff <= 1'b0;
      rd_s3_ff <= 1'b0;
    end else if (ce_i) begin
      ext_s1_ff <= ext_trig_i;
      ext_s2_ff <= ext_s1_ff;
      ext_s3_ff <= ext_s2_ff;
      rd_s1_ff <= readout_done_i;
      rd_s2_ff <= rd_s1_ff;
      rd_s3_ff <= rd_s2_ff;
    end
  end

  // Internal trigger: marker pulse every iper cycles
  always @(posedge clk_i) begin
    if (rst_i) begin
      icount_ff <= {W{1'b0}};
      mk_ff <= 16'h0000;
      cycle_start_marker_o <= 1'b0;
      marker_q_ff <= 1'b0;
    end else if (ce_i) begin
      // Delayed copy for the marker rising edge detector
      marker_q_ff <= cycle_start_marker_o;
      if (!ctrl_ff[`CTRL_INT_TRIG] || iper_ff == {W{1'b0}}) begin
        icount_ff <= {W{1'b0}};
        cycle_start_marker_o <= 1'b0;
      end else if (icount_ff >= iper_ff - {{(W-1){1'b0}}, 1'b1}) begin
        icount_ff <= {W{1'b0}};
        cycle_start_marker_o <= 1'b1;
        mk_ff <= `MARKER_CYCLES;
      end else begin
        icount_ff <= inc(icount_ff);
        if (mk_ff != 16'h0000) begin
          mk_ff <= mk_ff - 16'h0001;
        end else begin
          cycle_start_marker_o <= 1'b0;
        end
      end
    end
  end

  // Pair sequencer
  always @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= S_IDLE;
      start_ff <= 1'b0;
      sel_end_ff <= 1'b0;
      bcount_ff <= {W{1'b0}};
      gate_o <= 1'b0;
      transfer_o <= 1'b0;
      stored_ff <= 1'b0;
      pair_busy_o <= 1'b0;
      pairs_ff <= 8'h00;
    end else if (ce_i) begin
      start_ff <= 1'b0;
      transfer_o <= 1'b0;
      gate_o <= p_gate;
      // Only the first shift sets the flag again below, so the set wins; the second shift leaves it clear
      if (stored_ff && rd_rise) begin // RL10
        stored_ff <= 1'b0;
      end
      case (st_ff)
        S_IDLE: begin
          pair_busy_o <= 1'b0;
          if (trig && cfg_ok && !stored_ff) begin
            start_ff <= 1'b1;
            sel_end_ff <= 1'b0;
            bcount_ff <= {{(W-1){1'b0}}, 1'b1};
            pair_busy_o <= 1'b1;
            st_ff <= S_FIRST;
          end
        end
        S_FIRST: begin
          // Triggers here are dropped, a pair never restarts
          bcount_ff <= inc(bcount_ff); // RL18
          if (p_done) begin
            transfer_o <= 1'b1; // RL9
            stored_ff <= 1'b1; // RL9
            st_ff <= S_WAIT2;
          end
        end
        S_WAIT2: begin
          bcount_ff <= inc(bcount_ff);
          if (two_trig) begin
            if (trig) begin // RL6
              start_ff <= 1'b1;
              sel_end_ff <= stepped; // RL7
              st_ff <= S_SECOND;
            end
          end else if (bcount_ff >= bper_ff) begin
            // Burst: no trigger, same settings, spaced by period
            start_ff <= 1'b1; // RL1
            sel_end_ff <= 1'b0; // RL5
            st_ff <= S_SECOND; // RL3
          end
        end
        S_SECOND: begin
          if (p_done) begin
            st_ff <= S_HOLD;
          end
        end
        S_HOLD: begin
          // Second charge stays in active columns until readout ends
          if (!stored_ff || rd_rise) begin // RL10
            transfer_o <= 1'b1;
            pairs_ff <= pairs_ff + 8'h01;
            st_ff <= S_IDLE; // RL19
          end
        end
        default: st_ff <= S_IDLE;
      endcase
    end
  end

  // Wishbone slave, one wait state, unmapped reads zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
      ctrl_ff <= 5'h00;
      dly_s_ff <= {W{1'b0}};
      wid_s_ff <= {W{1'b0}};
      dly_e_ff <= {W{1'b0}};
      wid_e_ff <= {W{1'b0}};
      bper_ff <= {W{1'b0}};
      settle_ff <= {W{1'b0}};
      iper_ff <= {W{1'b0}};
      bcnt_ff <= `PAIR_COUNT;
      icnt_ff <= `PAIR_COUNT;
    end else if (ce_i) begin
      ack_o <= bus_req;
      if (bus_req && we_i) begin
        // Host loads all settings before acquisition
        case (widx) // RL16
          `ADR_CTRL: ctrl_ff <= ctrl_wr[4:0];
          `ADR_DLY_START: dly_s_ff <= merge(dly_s_ff, dat_i, sel_i);
          `ADR_WID_START: wid_s_ff <= merge(wid_s_ff, dat_i, sel_i);
          `ADR_DLY_END: dly_e_ff <= merge(dly_e_ff, dat_i, sel_i);
          `ADR_WID_END: wid_e_ff <= merge(wid_e_ff, dat_i, sel_i);
          `ADR_BURST_PER: bper_ff <= merge(bper_ff, dat_i, sel_i); // RL4
          `ADR_SETTLE: settle_ff <= merge(settle_ff, dat_i, sel_i);
          `ADR_INT_PER: iper_ff <= merge(iper_ff, dat_i, sel_i);
          `ADR_BURST_CNT: if (sel_i[0]) bcnt_ff <= dat_i[1:0];
          `ADR_IMG_CNT: if (sel_i[0]) icnt_ff <= dat_i[1:0];
          default: ;
        endcase
      end
      // Read data stands until the next read
      if (bus_req && !we_i) begin
        case (widx)
          `ADR_CTRL: dat_o <= {27'h0, ctrl_ff};
          `ADR_STATUS: dat_o <= {16'h0, pairs_ff, 2'h0, cfg_ok, p_busy, stored_ff, st_ff};
          `ADR_DLY_START: dat_o <= dly_s_ff;
          `ADR_WID_START: dat_o <= wid_s_ff;
          `ADR_DLY_END: dat_o <= dly_e_ff;
          `ADR_WID_END: dat_o <= wid_e_ff;
          `ADR_BURST_PER: dat_o <= bper_ff;
          `ADR_SETTLE: dat_o <= settle_ff;
          `ADR_INT_PER: dat_o <= iper_ff;
          `ADR_BURST_CNT: dat_o <= {30'h0, bcnt_ff};
          `ADR_IMG_CNT: dat_o <= {30'h0, icnt_ff};
          default: dat_o <= 32'h00000000;
        endcase
      end
    end
  end
endmodule

// file: dexp_chk_assertions.sv
// Checker of bus, gate and transfer timing at the sequencer ports
`timescale 1ns/100ps
module dexp_chk (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire cyc_i,
  input wire stb_i,
  input wire ack_o,
  input wire gate_o,
  input wire transfer_o,
  input wire cycle_start_marker_o,
  input wire pair_busy_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  reg [2:0] g_ff;
  // Gate pulses of the running pair, cleared while idle
  always @(posedge clk_i) begin
    if (rst_i || !pair_busy_o)
      g_ff <= 3'h0;
    else if ($rose(gate_o))
      g_ff <= g_ff + 3'h1;
  end
  sequence mark_s;
    cycle_start_marker_o [*5] ##1 !cycle_start_marker_o;
  endsequence
  ack_resp_a: assert property (cyc_i && stb_i && !ack_o && ce_i |=> ack_o)
    else $error("ack missing");
  ack_once_a: assert property (ack_o |=> !ack_o)
    else $error("ack too long");
  ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  gate_in_pair_a: assert property (gate_o |-> pair_busy_o)
    else $error("gate outside pair");
  xfer_pulse_a: assert property (transfer_o |=> !transfer_o)
    else $error("transfer too long");
  xfer_settle_a: assert property (transfer_o |-> !gate_o)
    else $error("shift during gate");
  marker_width_a: assert property ($rose(cycle_start_marker_o) |-> mark_s)
    else $error("marker width");
  pair_two_a: assert property ($fell(pair_busy_o) |-> g_ff == 3'h2)
    else $error("pulse count");
endmodule
bind double_exposure_gate_sequencer dexp_chk chk (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i,
  .ack_o, .gate_o, .transfer_o, .cycle_start_marker_o, .pair_busy_o);

// file: dexp_partner.sv
// Trigger source and readout model on the camera side
`timescale 1ns/100ps
module dexp_partner #(
  parameter RD_LAT = 60
) (
  input wire clk_i,
  input wire fire_i,
  input wire transfer_i,
  output reg trig_o,
  output reg rdone_o
);
  reg [2:0] t_ff = 3'h0;
  integer rd_n = 0;
  initial trig_o = 1'b0;
  initial rdone_o = 1'b0;
  // Trigger held four cycles so the synchroniser cannot miss it
  always @(posedge clk_i) begin
    if (fire_i)
      t_ff <= 3'h4;
    else if (t_ff != 3'h0)
      t_ff <= t_ff - 3'h1;
    trig_o <= fire_i || t_ff > 3'h1;
  end
  // Each shift starts a fresh readout; done is a level after RD_LAT
  always @(posedge clk_i) begin
    if (transfer_i) begin
      rdone_o <= 1'b0;
      rd_n <= RD_LAT;
    end else if (rd_n == 1) begin
      rdone_o <= 1'b1;
      rd_n <= 0;
    end else if (rd_n > 1)
      rd_n <= rd_n - 1;
  end
endmodule

// file: double_exposure_gate_sequencer_bench.sv
// Self-checking bench for the double exposure sequencer
`timescale 1ns/100ps
`include "dexp_defines.vh"
module double_exposure_gate_sequencer_bench;
  reg clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, fire = 1'b0;
  reg [5:0] adr_i = 6'h00;
  reg [31:0] dat_i = 32'h0, q;
  wire [31:0] dat_o;
  wire ack_o, gate_o, transfer_o, marker, pair_busy_o, trig, rdone;
  integer err_count = 0, n_checks = 0, cyc_n = 0, g_n = 0, x_n = 0, f_t, f1, i;
  integer g_t[0:7], g_w[0:7], x_t[0:7];
  reg gate_q = 1'b0;
  always #25 clk_i = ~clk_i;
  double_exposure_gate_sequencer uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'hf),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .ext_trig_i(trig),
    .readout_done_i(rdone), .gate_o(gate_o), .transfer_o(transfer_o),
    .cycle_start_marker_o(marker), .pair_busy_o(pair_busy_o));
  dexp_partner far (.clk_i(clk_i), .fire_i(fire), .transfer_i(transfer_o),
    .trig_o(trig), .rdone_o(rdone));
  // Gate starts, widths and shift times, plus the hang guard
  always @(posedge clk_i) begin
    cyc_n = cyc_n + 1;
    if (gate_o === 1'b1 && gate_q !== 1'b1)
      g_t[g_n & 7] = cyc_n;
    if (gate_o === 1'b1 && gate_q !== 1'b1)
      g_w[g_n & 7] = 0;
    if (gate_o === 1'b1)
      g_w[g_n & 7] = g_w[g_n & 7] + 1;
    if (gate_o !== 1'b1 && gate_q === 1'b1)
      g_n = g_n + 1;
    if (transfer_o === 1'b1)
      x_t[x_n & 7] = cyc_n;
    if (transfer_o === 1'b1)
      x_n = x_n + 1;
    gate_q = gate_o;
    if (cyc_n == 20000)
      err_count = err_count + 1;
    if (cyc_n == 20000)
      end_of_test;
  end
  task check(input [63:0] nm, input [31:0] seen, input [31:0] exp);
  begin
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("wrong value %0s expected %h seen %h", nm, exp, seen);
    end
  end
  endtask
  // One classic cycle; holds everything until ack is sampled
  task wb(input w, input [3:0] a, input [31:0] d);
    integer n;
  begin
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {a, 2'b00};
    dat_i <= d;
    n = 0;
    @(posedge clk_i);
    // No local limit: only the bench timeout ends this wait
    while (ack_o !== 1'b1) begin
      @(posedge clk_i);
      n = n + 1;
    end
    q = dat_o;
    check("acklat", n, 1);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  end
  endtask
  task fire_trig;
  begin
    @(posedge clk_i);
    fire <= 1'b1;
    f_t = cyc_n;
    @(posedge clk_i);
    fire <= 1'b0;
  end
  endtask
  // Waits for the pair to end, then for the last readout
  task wait_idle;
  begin
    i = 0;
    while (pair_busy_o !== 1'b0 && i < 3000) begin
      @(posedge clk_i);
      i = i + 1;
    end
    check("idle", pair_busy_o, 0);
    repeat (90) @(posedge clk_i);
  end
  endtask
  // Full download before acquisition; period covers 3+4+5
  task cfg(input [31:0] c);
  begin
    wb(1, `ADR_DLY_START, 32'h3);
    wb(1, `ADR_WID_START, 32'h4);
    wb(1, `ADR_DLY_END, 32'h6);
    wb(1, `ADR_WID_END, 32'h9);
    wb(1, `ADR_BURST_PER, 32'h18);
    wb(1, `ADR_SETTLE, 32'h5);
    wb(1, `ADR_INT_PER, 32'h12c);
    wb(1, `ADR_CTRL, c);
    wb(0, `ADR_CTRL, 32'h0);
    check("ctrl", q, c);
    g_n = 0;
    x_n = 0;
  end
  endtask
  task s_regs;
  begin
    wb(0, `ADR_BURST_CNT, 32'h0);
    check("burst", q, 32'h2);
    wb(0, `ADR_IMG_CNT, 32'h0);
    check("images", q, 32'h2);
    wb(1, 4'hf, 32'hffffffff);
    wb(0, 4'hf, 32'h0);
    check("unmap", q, 32'h0);
  end
  endtask
  task s_one;
  begin
    cfg(32'h05);
    fire_trig;
    repeat (40) @(posedge clk_i);
    check("nogated", g_n, 0);
    cfg(32'h15);
    fire_trig;
    repeat (10) @(posedge clk_i);
    fire_trig;
    wait_idle;
    check("pulses", g_n, 2);
    check("wid1", g_w[1], 4);
    check("wid0", g_w[0], 4);
    check("period", g_t[1] - g_t[0] >= 24 && g_t[1] - g_t[0] <= 25, 1);
    check("shifts", x_n, 2);
    check("settle", x_t[0] - g_t[0] - g_w[0] >= 4, 1);
    check("hold", x_t[1] - x_t[0] >= 60, 1);
  end
  endtask
  // Two triggers; stepped gives end values on the second
  task s_two(input [31:0] c, input integer w2, input integer dd);
  begin
    cfg(c);
    fire_trig;
    f1 = f_t;
    repeat (40) @(posedge clk_i);
    check("one", g_n, 1);
    check("busy", pair_busy_o, 1);
    fire_trig;
    wait_idle;
    check("two", g_n, 2);
    check("wid0", g_w[0], 4);
    check("wid1", g_w[1], w2);
    check("dly", (g_t[1] - f_t) - (g_t[0] - f1), dd);
    check("hold", x_t[1] - x_t[0] >= 60, 1);
  end
  endtask
  task s_int;
  begin
    cfg(32'h19);
    i = 0;
    while (marker !== 1'b1 && i < 400) begin
      @(posedge clk_i);
      i = i + 1;
    end
    f1 = cyc_n;
    g_n = 0;
    repeat (200) @(posedge clk_i);
    check("marker", i < 400, 1);
    check("intpair", g_n, 2);
    check("after", g_t[0] > f1, 1);
    wb(1, `ADR_CTRL, 32'h0);
    wait_idle;
  end
  endtask
  task end_of_test;
  begin
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    s_regs;
    s_one;
    s_two(32'h17, 9, 3);
    s_two(32'h13, 4, 0);
    s_int;
    end_of_test;
  end
endmodule
